// ### rtl/brc_pkg.sv
// Package with constants for the bridge reset control block.
// How it works
// - Hold power-on reset until supply good, refclk active, then ten microseconds.
// - Power-on reset clears everything and drives the secondary bus reset.
// - Global reset low forces a full reset asynchronously in all power states.
// - After global reset, static inputs are captured at fundamental reset release and held until the next reset.
// - After global reset or fundamental reset release, start EEPROM download if present.
// - Link training starts within eighty milliseconds after global reset release.
// - Fundamental reset clears non-sticky state and drives the secondary bus reset.
// - Fundamental reset release means power good: capture, download, train within limit.
// - A link hot reset moves the link interface into the link-down state.
// - Link-down resets non-sticky, non-EEPROM state and drives secondary bus reset.
// - Secondary reset bit in bridge control drives the secondary bus reset output.
// - Refclk type select low means 100 MHz differential, high 125 MHz single-ended.
package brc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int POR_WAIT_US = 10;
    localparam int POR_WAIT_CYC = POR_WAIT_US * CLK_MHZ;
    localparam int TRAIN_LIMIT_MS = 80;
    localparam int TRAIN_LIMIT_CYC = TRAIN_LIMIT_MS * 1000 * CLK_MHZ;
    localparam int TRAIN_DELAY_CYC_DEF = 16;
    // Bridge control is a word index, so its byte address is four times the index.
    localparam logic [11:0] IDX_BRIDGE_CONTROL = 12'h03E;
    localparam logic [11:0] ADDR_BRIDGE_CONTROL = IDX_BRIDGE_CONTROL << 2;
    localparam logic [11:0] ADDR_RESET_STATUS = 12'h040;
    localparam logic [11:0] ADDR_STATIC_CAPTURE = 12'h044;
    localparam int BRCTL_SEC_RESET_BIT = 6;
    localparam int BRCTL_SHIFT = 0;
    localparam logic [15:0] BRCTL_RESET = 16'h0000;
    localparam int STATIC_W = 8;
    localparam int REFCLK_TYPE_SELECT_BIT = 8;
    localparam int ST_POR_BIT = 0;
    localparam int ST_LINKDN_BIT = 1;
    localparam int ST_DL_BIT = 2;
    localparam int ST_TRAIN_BIT = 3;
    localparam int ST_SECRST_BIT = 4;
    localparam int ST_HOTRST_BIT = 5;
    localparam int CNT_W = 32;
    typedef enum logic [3:0] {
        BRC_WAIT_SUPPLY = 4'h1,
        BRC_WAIT_CLK = 4'h2,
        BRC_WAIT_DELAY = 4'h4,
        BRC_READY = 4'h8
    } brc_por_type;
endpackage : brc_pkg

// ### rtl/brc_sync.sv
// Two-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
`default_nettype none
module brc_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // First stage feeds only the second stage.
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q <= '0;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule : brc_sync
`default_nettype wire

// ### rtl/brc_top.sv
// Reset source merging, scope outputs, static capture and APB registers.
`timescale 1ns/1ps
`default_nettype none
module brc_top #(
    parameter int TRAIN_DELAY_CYC = brc_pkg::TRAIN_DELAY_CYC_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic global_reset_n,
    input wire logic perst_n,
    input wire logic core_supply_monitor,
    input wire logic refclk_active,
    input wire logic refclk_type_select,
    input wire logic hot_reset_rx,
    input wire logic eeprom_present,
    input wire logic [brc_pkg::STATIC_W-1:0] static_inputs,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic full_reset_n,
    output logic fundamental_reset_n,
    output logic link_down_reset_n,
    output logic secondary_bus_reset_out,
    output logic eeprom_download_start,
    output logic link_train_start,
    output logic refclk_single_ended_125,
    output logic [brc_pkg::STATIC_W-1:0] static_latched
);
    // Full reset: the bus reset or the global reset pin, both asynchronous.
    logic por_arst_n;
    assign por_arst_n = presetn & global_reset_n;

    // Synchronised pin levels.
    logic supply_s;
    logic clk_s;
    logic perst_s;
    logic hot_s;
    logic sel_s;
    logic [brc_pkg::STATIC_W-1:0] static_s;

    brc_sync #(.W(5 + brc_pkg::STATIC_W)) u_sync (
        .pclk(pclk),
        .rst_n(por_arst_n),
        .d({core_supply_monitor, refclk_active, perst_n, hot_reset_rx, refclk_type_select, static_inputs}),
        .q({supply_s, clk_s, perst_s, hot_s, sel_s, static_s})
    );

    // Power-on sequencer state.
    brc_pkg::brc_por_type por_ff;
    brc_pkg::brc_por_type nxt_por;
    logic [brc_pkg::CNT_W-1:0] por_cnt_ff;
    logic por_done;
    assign por_done = (por_ff == brc_pkg::BRC_READY);

    // Supply, then clock, then a fixed wait before release.
    always_comb begin
        nxt_por = por_ff;
        case (por_ff)
            brc_pkg::BRC_WAIT_SUPPLY: begin
                if (supply_s) begin
                    nxt_por = brc_pkg::BRC_WAIT_CLK;
                end
            end
            brc_pkg::BRC_WAIT_CLK: begin
                if (!supply_s) begin
                    nxt_por = brc_pkg::BRC_WAIT_SUPPLY;
                end else if (clk_s) begin
                    nxt_por = brc_pkg::BRC_WAIT_DELAY;
                end
            end
            brc_pkg::BRC_WAIT_DELAY: begin
                if (!supply_s || !clk_s) begin
                    nxt_por = brc_pkg::BRC_WAIT_SUPPLY;
                end else if (por_cnt_ff == brc_pkg::CNT_W'(brc_pkg::POR_WAIT_CYC - 1)) begin
                    nxt_por = brc_pkg::BRC_READY;
                end
            end
            brc_pkg::BRC_READY: begin
                nxt_por = brc_pkg::BRC_READY;
            end
            default: begin
                nxt_por = brc_pkg::BRC_WAIT_SUPPLY;
            end
        endcase
    end

    // Sequencer register, cleared by the full reset.
    always_ff @(posedge pclk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            por_ff <= brc_pkg::BRC_WAIT_SUPPLY;
        end else begin
            por_ff <= nxt_por;
        end
    end

    // Delay counter runs only in the wait state.
    always_ff @(posedge pclk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            por_cnt_ff <= '0;
        end else if (por_ff == brc_pkg::BRC_WAIT_DELAY) begin
            por_cnt_ff <= por_cnt_ff + 1'b1;
        end else begin
            por_cnt_ff <= '0;
        end
    end

    // Fundamental reset active while the pin is low or power-on is not done.
    logic fund_active;
    assign fund_active = !perst_s || !por_done;

    // Link-down state entered on hot or fundamental reset, left once both clear.
    logic dl_down_ff;
    always_ff @(posedge pclk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            dl_down_ff <= 1'b1;
        end else if (hot_s || fund_active) begin
            dl_down_ff <= 1'b1;
        end else begin
            dl_down_ff <= 1'b0;
        end
    end

    // A fundamental or link-down scope is active; both clear the same non-sticky state.
    function automatic logic wide_scope(input logic fund, input logic dl);
        wide_scope = fund || dl;
    endfunction : wide_scope

    // Scope outputs, each wider scope implying the narrower ones.
    always_ff @(posedge pclk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            full_reset_n <= 1'b0;
            fundamental_reset_n <= 1'b0;
            link_down_reset_n <= 1'b0;
        end else begin
            full_reset_n <= por_done;
            fundamental_reset_n <= !fund_active;
            link_down_reset_n <= !wide_scope(fund_active, dl_down_ff);
        end
    end

    // Release detection: end of any wider reset begins the post-reset actions.
    logic fund_active_d_ff;
    logic release_pulse;
    assign release_pulse = fund_active_d_ff && !fund_active;
    always_ff @(posedge pclk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            fund_active_d_ff <= 1'b1;
        end else begin
            fund_active_d_ff <= fund_active;
        end
    end

    // Static inputs and refclk type captured at release and held until next reset.
    logic refclk_type_select_ff;
    always_ff @(posedge pclk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            static_latched <= '0;
            refclk_type_select_ff <= 1'b0;
        end else if (release_pulse) begin
            static_latched <= static_s;
            refclk_type_select_ff <= sel_s;
        end
    end
    assign refclk_single_ended_125 = refclk_type_select_ff;

    // EEPROM download start pulse.
    always_ff @(posedge pclk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            eeprom_download_start <= 1'b0;
        end else begin
            eeprom_download_start <= release_pulse && eeprom_present;
        end
    end

    // Training delay counter after release; must stay under the limit.
    logic [brc_pkg::CNT_W-1:0] train_cnt_ff;
    logic train_wait_ff;
    always_ff @(posedge pclk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            train_wait_ff <= 1'b0;
            train_cnt_ff <= '0;
            link_train_start <= 1'b0;
        end else if (fund_active) begin
            train_wait_ff <= 1'b0;
            train_cnt_ff <= '0;
            link_train_start <= 1'b0;
        end else if (release_pulse) begin
            train_wait_ff <= 1'b1;
            train_cnt_ff <= '0;
            link_train_start <= 1'b0;
        end else if (train_wait_ff) begin
            train_cnt_ff <= train_cnt_ff + 1'b1;
            if (train_cnt_ff >= brc_pkg::CNT_W'(TRAIN_DELAY_CYC - 1)
                || train_cnt_ff >= brc_pkg::CNT_W'(brc_pkg::TRAIN_LIMIT_CYC - 1)) begin
                train_wait_ff <= 1'b0;
                link_train_start <= 1'b1;
            end
        end else begin
            link_train_start <= 1'b0;
        end
    end

    // Bridge control register, cleared by the fundamental and link-down scopes.
    logic [15:0] brctl_ff;
    logic wr_en;
    assign wr_en = psel && penable && pwrite;
    always_ff @(posedge pclk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            brctl_ff <= brc_pkg::BRCTL_RESET;
        end else if (wide_scope(fund_active, dl_down_ff)) begin
            brctl_ff <= brc_pkg::BRCTL_RESET;
        end else if (wr_en && paddr == brc_pkg::ADDR_BRIDGE_CONTROL) begin
            brctl_ff <= pwdata[brc_pkg::BRCTL_SHIFT +: 16];
        end
    end

    // Secondary bus reset while any source asks for it.
    always_ff @(posedge pclk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            secondary_bus_reset_out <= 1'b1;
        end else begin
            secondary_bus_reset_out <= wide_scope(fund_active, dl_down_ff)
                || brctl_ff[brc_pkg::BRCTL_SEC_RESET_BIT];
        end
    end

    // Read data mux, registered in the setup phase.
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        case (paddr)
            brc_pkg::ADDR_BRIDGE_CONTROL: begin
                rd_mux[brc_pkg::BRCTL_SHIFT +: 16] = brctl_ff;
            end
            brc_pkg::ADDR_RESET_STATUS: begin
                rd_mux[brc_pkg::ST_POR_BIT] = por_done;
                rd_mux[brc_pkg::ST_LINKDN_BIT] = fund_active;
                rd_mux[brc_pkg::ST_DL_BIT] = dl_down_ff;
                rd_mux[brc_pkg::ST_TRAIN_BIT] = train_wait_ff;
                rd_mux[brc_pkg::ST_SECRST_BIT] = secondary_bus_reset_out;
                rd_mux[brc_pkg::ST_HOTRST_BIT] = hot_s;
            end
            brc_pkg::ADDR_STATIC_CAPTURE: begin
                rd_mux[brc_pkg::STATIC_W-1:0] = static_latched;
                rd_mux[brc_pkg::REFCLK_TYPE_SELECT_BIT] = refclk_type_select_ff;
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // Register read data and error flag at setup.
    logic known;
    assign known = (paddr == brc_pkg::ADDR_BRIDGE_CONTROL) || (paddr == brc_pkg::ADDR_RESET_STATUS)
        || (paddr == brc_pkg::ADDR_STATIC_CAPTURE);
    logic err_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            err_ff <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h00000000 : rd_mux;
            err_ff <= !known;
        end
    end

    // Always ready; error reported only in the access phase.
    assign pready = 1'b1;
    assign pslverr = psel && penable && err_ff;
endmodule : brc_top
`default_nettype wire

// ### sim/brc_upstream.sv
// Upstream device and power control model.
`timescale 1ns/1ps
`default_nettype none
module brc_upstream (
    input wire logic pclk,
    output logic perst_n,
    output logic core_supply_monitor,
    output logic refclk_active,
    output logic hot_reset_rx
);
    // All off, with the fundamental reset held.
    initial {perst_n, core_supply_monitor, refclk_active, hot_reset_rx} = 4'h0;
    // Supply, then clock, then reset lifted.
    task automatic power_up();
        @(posedge pclk) core_supply_monitor <= 1'b1;
        @(posedge pclk) refclk_active <= 1'b1;
        @(posedge pclk) perst_n <= 1'b1;
    endtask : power_up
    // Reset goes low before clock and supply go.
    task automatic power_down();
        @(posedge pclk) perst_n <= 1'b0;
        @(posedge pclk) refclk_active <= 1'b0;
        @(posedge pclk) core_supply_monitor <= 1'b0;
    endtask : power_down
    // Sets both reset request levels.
    task automatic drive(input logic perst, input logic hot);
        perst_n <= perst;
        hot_reset_rx <= hot;
    endtask : drive
endmodule : brc_upstream
`default_nettype wire

// ### sim/brc_top_chk.sv
// Concurrent checks on reset scopes and pulses.
`timescale 1ns/1ps
`default_nettype none
module brc_top_chk #(parameter int TRAIN_DELAY_CYC = 16) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic global_reset_n,
    input wire logic hot_reset_rx,
    input wire logic full_reset_n,
    input wire logic fundamental_reset_n,
    input wire logic link_down_reset_n,
    input wire logic secondary_bus_reset_out,
    input wire logic eeprom_download_start,
    input wire logic link_train_start,
    input wire logic [brc_pkg::STATIC_W-1:0] static_latched
);
    localparam int TMAX = TRAIN_DELAY_CYC + 4;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !global_reset_n);
    // Fundamental release and a new hot reset request.
    sequence s_release; $rose(fundamental_reset_n); endsequence
    sequence s_hot; $rose(hot_reset_rx) && fundamental_reset_n; endsequence
    a_full_nest: assert property (!full_reset_n |-> !fundamental_reset_n) else $error("scope order");
    a_fund_nest: assert property (!fundamental_reset_n |-> !link_down_reset_n) else $error("scope order");
    a_sbr_held: assert property (!link_down_reset_n [*2] |-> secondary_bus_reset_out) else $error("sbr low");
    a_train_window: assert property (s_release |-> ##[0:TMAX] link_train_start) else $error("no train");
    a_train_single: assert property (link_train_start |=> !link_train_start) else $error("long train");
    a_ee_single: assert property (eeprom_download_start |=> !eeprom_download_start) else $error("long ee");
    a_strap_hold: assert property (fundamental_reset_n [*4] |-> $stable(static_latched)) else $error("moved");
    a_hot_down: assert property (s_hot |-> ##[1:5] !link_down_reset_n) else $error("no link down");
endmodule : brc_top_chk
bind brc_top brc_top_chk #(.TRAIN_DELAY_CYC(TRAIN_DELAY_CYC)) chk (
    .pclk(pclk),
    .presetn(presetn),
    .global_reset_n(global_reset_n),
    .hot_reset_rx(hot_reset_rx),
    .full_reset_n(full_reset_n),
    .fundamental_reset_n(fundamental_reset_n),
    .link_down_reset_n(link_down_reset_n),
    .secondary_bus_reset_out(secondary_bus_reset_out),
    .eeprom_download_start(eeprom_download_start),
    .link_train_start(link_train_start),
    .static_latched(static_latched)
);
`default_nettype wire

// ### sim/brc_top_tb.sv
// Self-checking testbench for the reset control block.
`timescale 1ns/1ps
`default_nettype none
module brc_top_tb;
    localparam int TD = 4;
    localparam logic [11:0] BC = brc_pkg::ADDR_BRIDGE_CONTROL;
    // Word with only the secondary reset bit of bridge control set.
    localparam logic [31:0] SRW = 32'h0000_0001 << (brc_pkg::BRCTL_SHIFT + brc_pkg::BRCTL_SEC_RESET_BIT);
    logic pclk = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, e;
    logic presetn = 1'b0, global_reset_n = 1'b1, refclk_type_select = 1'b1, eeprom_present = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [7:0] static_inputs = 8'hA5, static_latched;
    logic pready, pslverr, full_reset_n, fundamental_reset_n, link_down_reset_n, secondary_bus_reset_out;
    logic eeprom_download_start, link_train_start, refclk_single_ended_125;
    wire logic perst_n, core_supply_monitor, refclk_active, hot_reset_rx;
    wire logic [3:0] scope = {full_reset_n, fundamental_reset_n, link_down_reset_n, secondary_bus_reset_out};
    int miscompares = 0, checks = 0, n;
    brc_top #(.TRAIN_DELAY_CYC(TD)) dut (
        .pclk(pclk), .presetn(presetn), .global_reset_n(global_reset_n), .perst_n(perst_n),
        .core_supply_monitor(core_supply_monitor), .refclk_active(refclk_active),
        .refclk_type_select(refclk_type_select), .hot_reset_rx(hot_reset_rx), .eeprom_present(eeprom_present),
        .static_inputs(static_inputs), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .full_reset_n(full_reset_n),
        .fundamental_reset_n(fundamental_reset_n), .link_down_reset_n(link_down_reset_n),
        .secondary_bus_reset_out(secondary_bus_reset_out), .eeprom_download_start(eeprom_download_start),
        .link_train_start(link_train_start), .refclk_single_ended_125(refclk_single_ended_125),
        .static_latched(static_latched)
    );
    brc_upstream up (
        .pclk(pclk), .perst_n(perst_n), .core_supply_monitor(core_supply_monitor),
        .refclk_active(refclk_active), .hot_reset_rx(hot_reset_rx)
    );
    // Clock of 100 MHz.
    initial forever #5 pclk = ~pclk;
    // Compares and logs a mismatch.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Verdict; a hung wait counts as a mismatch.
    task automatic report_and_stop(input logic hung);
        miscompares += hung;
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // One APB transfer and an idle cycle.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) report_and_stop(1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask : apb
    // Bounded wait for full release or the training pulse.
    task automatic wait_for(input logic train);
        for (n = 0; n < 1100 && (train ? link_train_start : full_reset_n) !== 1'b1; n++) begin
            @(posedge pclk);
            e = e | eeprom_download_start;
        end
        if (n >= 1100) report_and_stop(1'b1);
    endtask : wait_for
    // Power-up wait, straps and start pulses.
    task automatic s_power_on();
        e = 1'b0;
        up.power_up();
        chk(scope, 4'b0001);
        wait_for(1'b0);
        chk(n >= 995 && n <= 1010, 1'b1);
        wait_for(1'b1);
        chk({e, n <= TD + 4}, 2'b11);
        repeat (2) @(posedge pclk);
        chk({refclk_single_ended_125, static_latched}, 9'h1A5);
    endtask : s_power_on
    // Software secondary reset, then an unmapped access.
    task automatic s_brctl();
        apb(1'b1, BC, SRW);
        apb(1'b0, BC, 32'h0000_0000);
        chk({|(rd & SRW), scope}, 5'h1F);
        apb(1'b1, BC, 32'h0000_0000);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk({err, scope}, 5'h1E);
    endtask : s_brctl
    // Fundamental reset clears state; straps recaptured on release.
    task automatic s_perst();
        static_inputs <= 8'h3C;
        refclk_type_select <= 1'b0;
        up.drive(1'b0, 1'b0);
        repeat (5) @(posedge pclk);
        chk({scope, static_latched}, 12'h9A5);
        apb(1'b1, BC, SRW);
        apb(1'b0, BC, 32'h0000_0000);
        chk(|(rd & SRW), 1'b0);
        e = 1'b0;
        up.drive(1'b1, 1'b0);
        wait_for(1'b1);
        chk({e, n <= TD + 8}, 2'b11);
        repeat (2) @(posedge pclk);
        chk({refclk_single_ended_125, static_latched}, 9'h03C);
        apb(1'b0, brc_pkg::ADDR_STATIC_CAPTURE, 32'h0000_0000);
        chk(rd, 32'h0000_003C);
    endtask : s_perst
    // Hot reset gives the link-down scope only.
    task automatic s_hot();
        up.drive(1'b1, 1'b1);
        repeat (6) @(posedge pclk);
        chk(scope, 4'b1101);
        apb(1'b0, brc_pkg::ADDR_RESET_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0035);
        up.drive(1'b1, 1'b0);
        repeat (6) @(posedge pclk);
        chk(scope, 4'b1110);
    endtask : s_hot
    // Global reset acts with no clock edge; then power is removed.
    task automatic s_global_reset_n();
        global_reset_n <= 1'b0;
        #2;
        chk(scope, 4'b0001);
        @(posedge pclk);
        global_reset_n <= 1'b1;
        wait_for(1'b0);
        chk(n >= 995 && n <= 1010, 1'b1);
        up.power_down();
        repeat (3) @(posedge pclk);
        chk(scope[2], 1'b0);
    endtask : s_global_reset_n
    // Reset for three cycles, then each scenario.
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        s_power_on();
        s_brctl();
        s_perst();
        s_hot();
        s_global_reset_n();
        report_and_stop(1'b0);
    end
endmodule : brc_top_tb
`default_nettype wire
